// >>> src/sbst_tap.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Inputs on link-clock rise, output on fall
// - Undriven mode and data inputs read high
// - Data enters MSB, leaves from LSB
// - Output enable follows controller state
// - Five mode-high rises reset the port
// - Power-up reset leaves output high impedance
// - Three-bit instruction, identification after reset
// - Instruction capture loads binary 01 low
// - One-bit bypass, cleared on capture
// - Boundary register captures pin ring, shifts
// - Identification capture loads fixed 32-bit code
// - Instruction acts at update; one register
// - EXTEST drives preloaded cells, selects boundary
// - Identification code shifts out in shift-data
// - Output-floating sample floats outputs, selects boundary
// - SAMPLE/PRELOAD snapshots pins at capture
// - Preload shifts in while sample shifts out
// - Tristate cell latches on update, gates outputs
// - Tristate cell preset high at reset
// - Code bit 0 one, vendor bits 11:1
module sbst_tap (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tmsDriven,
  input wire logic tdi,
  input wire logic tdiDriven,
  output logic tdo,
  output logic tdoOe_n,
  input wire logic ringValid,
  output logic ringReady,
  input wire logic [sbst_pkg::BSR_W-1:0] ringData,
  output logic [sbst_pkg::BSR_W-1:0] cellOut,
  output logic pinOverride,
  output logic memOutFloat
);

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rstPipe_r;
  wire rstSync_n = rstPipe_r[1];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rstPipe_r <= 2'h0;
    else
      rstPipe_r <= {rstPipe_r[0], 1'b1};
  end

  // Undriven inputs read high as if pulled up; the clock rests low
  logic [4:0] syncA_r;
  logic [4:0] syncB_r;
  logic tckLast_r;
  wire [4:0] pinRaw = {tck, tms, tmsDriven, tdi, tdiDriven};

  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      syncA_r <= 5'h0f;
      syncB_r <= 5'h0f;
      tckLast_r <= 1'b0;
    end
    else
    begin
      syncA_r <= pinRaw;
      syncB_r <= syncA_r;
      tckLast_r <= syncB_r[4];
    end
  end

  wire tckS = syncB_r[4];
  wire tmsIn = syncB_r[3] || !syncB_r[2];
  wire tdiIn = syncB_r[1] || !syncB_r[0];
  wire tckRise = tckS && !tckLast_r;
  wire tckFall = !tckS && tckLast_r;

  // ----------------------------------------------------------------
  // Controller
  // ----------------------------------------------------------------
  sbst_pkg::sbst_state_t state_r;
  sbst_pkg::sbst_state_t state_nxt;

  always_comb
  begin
    unique case (state_r)
      sbst_pkg::ST_TLR:
        state_nxt = tmsIn ? sbst_pkg::ST_TLR : sbst_pkg::ST_RTI;
      sbst_pkg::ST_RTI:
        state_nxt = tmsIn ? sbst_pkg::ST_SELDR : sbst_pkg::ST_RTI;
      sbst_pkg::ST_SELDR:
        state_nxt = tmsIn ? sbst_pkg::ST_SELIR : sbst_pkg::ST_CAPDR;
      sbst_pkg::ST_CAPDR:
        state_nxt = tmsIn ? sbst_pkg::ST_EX1DR : sbst_pkg::ST_SHDR;
      sbst_pkg::ST_SHDR:
        state_nxt = tmsIn ? sbst_pkg::ST_EX1DR : sbst_pkg::ST_SHDR;
      sbst_pkg::ST_EX1DR:
        state_nxt = tmsIn ? sbst_pkg::ST_UPDDR : sbst_pkg::ST_PAUSEDR;
      sbst_pkg::ST_PAUSEDR:
        state_nxt = tmsIn ? sbst_pkg::ST_EX2DR : sbst_pkg::ST_PAUSEDR;
      sbst_pkg::ST_EX2DR:
        state_nxt = tmsIn ? sbst_pkg::ST_UPDDR : sbst_pkg::ST_SHDR;
      sbst_pkg::ST_UPDDR:
        state_nxt = tmsIn ? sbst_pkg::ST_SELDR : sbst_pkg::ST_RTI;
      sbst_pkg::ST_SELIR:
        state_nxt = tmsIn ? sbst_pkg::ST_TLR : sbst_pkg::ST_CAPIR;
      sbst_pkg::ST_CAPIR:
        state_nxt = tmsIn ? sbst_pkg::ST_EX1IR : sbst_pkg::ST_SHIR;
      sbst_pkg::ST_SHIR:
        state_nxt = tmsIn ? sbst_pkg::ST_EX1IR : sbst_pkg::ST_SHIR;
      sbst_pkg::ST_EX1IR:
        state_nxt = tmsIn ? sbst_pkg::ST_UPDIR : sbst_pkg::ST_PAUSEIR;
      sbst_pkg::ST_PAUSEIR:
        state_nxt = tmsIn ? sbst_pkg::ST_EX2IR : sbst_pkg::ST_PAUSEIR;
      sbst_pkg::ST_EX2IR:
        state_nxt = tmsIn ? sbst_pkg::ST_UPDIR : sbst_pkg::ST_SHIR;
      sbst_pkg::ST_UPDIR:
        state_nxt = tmsIn ? sbst_pkg::ST_SELDR : sbst_pkg::ST_RTI;
      default:
        state_nxt = sbst_pkg::ST_TLR;
    endcase
  end

  // Power-up lands in test-logic reset, so the output starts floating
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
      state_r <= sbst_pkg::ST_TLR;
    else if (tckRise)
      state_r <= state_nxt;
  end

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  // Reserved codes fall back to bypass, the shortest harmless path
  function automatic sbst_pkg::sbst_sel_t drSelect(
    input logic [sbst_pkg::IR_W-1:0] op);
    case (op)
      sbst_pkg::OP_IDCODE: drSelect = sbst_pkg::SEL_ID;
      sbst_pkg::OP_EXTEST,
      sbst_pkg::OP_SAMPLEZ,
      sbst_pkg::OP_SAMPLE: drSelect = sbst_pkg::SEL_BSR;
      default: drSelect = sbst_pkg::SEL_BYPASS;
    endcase
  endfunction

  logic [sbst_pkg::IR_W-1:0] ir_r;
  logic [sbst_pkg::IR_W-1:0] irSh_r;
  logic [sbst_pkg::ID_W-1:0] idSh_r;
  logic [sbst_pkg::BSR_W-1:0] bsrSh_r;
  logic bypass_r;

  wire sbst_pkg::sbst_sel_t sel = drSelect(ir_r);
  wire selBsr = (sel == sbst_pkg::SEL_BSR);
  wire selId = (sel == sbst_pkg::SEL_ID);
  wire selByp = (sel == sbst_pkg::SEL_BYPASS);
  wire inTlr = (state_r == sbst_pkg::ST_TLR);
  wire atCapDr = tckRise && (state_r == sbst_pkg::ST_CAPDR);
  wire atShDr = tckRise && (state_r == sbst_pkg::ST_SHDR);
  wire atUpdDr = tckRise && (state_r == sbst_pkg::ST_UPDDR);
  wire atCapIr = tckRise && (state_r == sbst_pkg::ST_CAPIR);
  wire atShIr = tckRise && (state_r == sbst_pkg::ST_SHIR);
  wire atUpdIr = tckRise && (state_r == sbst_pkg::ST_UPDIR);
  wire shiftNow = (state_r == sbst_pkg::ST_SHDR) ||
    (state_r == sbst_pkg::ST_SHIR);

  // ----------------------------------------------------------------
  // Pin ring snapshots
  // ----------------------------------------------------------------
  // The ring side may stall: snapshots wait here until a capture with the boundary register selected
  logic snapValid;
  logic [sbst_pkg::BSR_W-1:0] snapData;
  wire snapTake = atCapDr && selBsr;

  sbst_fifo #(
    .WIDTH(sbst_pkg::BSR_W),
    .DEPTH(sbst_pkg::FIFO_DEPTH)
  ) u_snapFifo (
    .clk(clk),
    .rstSync_n(rstSync_n),
    .inValid(ringValid),
    .inReady(ringReady),
    .inData(ringData),
    .outValid(snapValid),
    .outReady(snapTake),
    .outData(snapData)
  );

  // ----------------------------------------------------------------
  // Instruction and data registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      ir_r <= sbst_pkg::OP_IDCODE;
      irSh_r <= sbst_pkg::OP_IDCODE;
    end
    else if (inTlr)
      ir_r <= sbst_pkg::OP_IDCODE;
    else if (atCapIr)
      irSh_r <= {sbst_pkg::IR_CAPTURE_MSB, sbst_pkg::IR_CAPTURE_LSB};
    else if (atShIr)
      irSh_r <= {tdiIn, irSh_r[sbst_pkg::IR_W-1:1]};
    else if (atUpdIr)
      ir_r <= irSh_r;
  end

  // An empty snapshot queue leaves the boundary shift register holding whatever it last held
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      bsrSh_r <= '0;
      idSh_r <= '0;
      bypass_r <= 1'b0;
    end
    else if (atCapDr)
    begin
      if (selBsr && snapValid)
        bsrSh_r <= snapData;
      if (selId)
        idSh_r <= sbst_pkg::ID_CODE;
      if (selByp)
        bypass_r <= 1'b0;
    end
    else if (atShDr)
    begin
      if (selBsr)
        bsrSh_r <= {tdiIn, bsrSh_r[sbst_pkg::BSR_W-1:1]};
      if (selId)
        idSh_r <= {tdiIn, idSh_r[sbst_pkg::ID_W-1:1]};
      if (selByp)
        bypass_r <= tdiIn;
    end
  end

  // Update stage: parallel cells, tristate cell preset high
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      cellOut <= '0;
      cellOut[sbst_pkg::TRI_CELL] <= 1'b1;
    end
    else if (inTlr)
      cellOut[sbst_pkg::TRI_CELL] <= 1'b1;
    else if (atUpdDr && selBsr)
      cellOut <= bsrSh_r;
  end

  wire isExtest = (ir_r == sbst_pkg::OP_EXTEST);
  wire isSampleZ = (ir_r == sbst_pkg::OP_SAMPLEZ);
  assign pinOverride = isExtest;
  assign memOutFloat = isSampleZ ||
    (isExtest && !cellOut[sbst_pkg::TRI_CELL]);

  // ----------------------------------------------------------------
  // Serial output, changed on the falling link edge
  // ----------------------------------------------------------------
  wire tdoBit = (state_r == sbst_pkg::ST_SHIR) ? irSh_r[0] :
    selBsr ? bsrSh_r[0] : selId ? idSh_r[0] : bypass_r;

  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      tdo <= 1'b0;
      tdoOe_n <= 1'b1;
    end
    else if (tckFall)
    begin
      tdo <= tdoBit;
      tdoOe_n <= !shiftNow;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [2:0] tmsRun_r;
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
      tmsRun_r <= '0;
    else if (tckRise)
      tmsRun_r <= !tmsIn ? '0 :
        (tmsRun_r == 3'(sbst_pkg::TMS_RESET_RUN)) ? tmsRun_r :
        tmsRun_r + 1'b1;
  end

  chk_tdo_idle_float: assert property (@(posedge clk)
    disable iff (!rstSync_n) tckFall && !shiftNow |=> tdoOe_n)
    else $error("serial output driven outside shift");
  chk_tdo_edge_only: assert property (@(posedge clk)
    disable iff (!rstSync_n)
    $changed(tdo) || $changed(tdoOe_n) |-> $past(tckFall))
    else $error("serial output moved off the falling edge");
  chk_five_ones_reset: assert property (@(posedge clk)
    disable iff (!rstSync_n) tmsRun_r == 3'(sbst_pkg::TMS_RESET_RUN) |-> inTlr)
    else $error("five high mode samples did not reset");
  chk_ir_reset_id: assert property (@(posedge clk)
    disable iff (!rstSync_n) inTlr ##1 inTlr |-> ir_r == sbst_pkg::OP_IDCODE)
    else $error("instruction not identification in reset");
  chk_ir_capture_bits: assert property (@(posedge clk)
    disable iff (!rstSync_n)
    atCapIr |=> irSh_r[1:0] == sbst_pkg::IR_CAPTURE_LSB)
    else $error("instruction capture pattern wrong");
  chk_bypass_cleared: assert property (@(posedge clk)
    disable iff (!rstSync_n) atCapDr && selByp |=> !bypass_r)
    else $error("bypass bit not cleared on capture");
  chk_id_capture_word: assert property (@(posedge clk)
    disable iff (!rstSync_n)
    atCapDr && selId |=> idSh_r == sbst_pkg::ID_CODE && idSh_r[0])
    else $error("identification word not captured");
  chk_bsr_msb_entry: assert property (@(posedge clk)
    disable iff (!rstSync_n)
    atShDr && selBsr |=> bsrSh_r[sbst_pkg::BSR_W-1] == $past(tdiIn))
    else $error("serial data did not enter at the top");
  chk_samplez_float: assert property (@(posedge clk)
    disable iff (!rstSync_n) isSampleZ |-> memOutFloat && !pinOverride)
    else $error("outputs not floated under sample-z");
  chk_tristate_preset: assert property (@(posedge clk)
    disable iff (!rstSync_n) inTlr |=> cellOut[sbst_pkg::TRI_CELL])
    else $error("tristate cell not preset in reset");

endmodule

// >>> shared/sbst_pkg.sv
package sbst_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int BSR_W = 90;
  localparam int TRI_CELL = 89;
  localparam int FIFO_DEPTH = 32;
  localparam int TMS_RESET_RUN = 5;

  // Fastest link clock the port is built for; sampled at 100 MHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int TCK_MIN_PERIOD_NS = 50;
  localparam int TCK_MIN_CYCLES = TCK_MIN_PERIOD_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [IR_W-1:0] OP_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] OP_IDCODE = 3'h1;
  localparam logic [IR_W-1:0] OP_SAMPLEZ = 3'h2;
  localparam logic [IR_W-1:0] OP_SAMPLE = 3'h4;
  localparam logic [IR_W-1:0] OP_BYPASS = 3'h7;
  localparam logic [1:0] IR_CAPTURE_LSB = 2'h1;
  localparam logic IR_CAPTURE_MSB = 1'h0;

  // ----------------------------------------------------------------
  // Identification word; field values are arbitrary
  // ----------------------------------------------------------------
  localparam logic [2:0] ID_REVISION = 3'h1;
  localparam logic [4:0] ID_DEPTH = 5'h02;
  localparam logic [5:0] ID_WIDTH = 6'h03;
  localparam logic [5:0] ID_DEVICE = 6'h04;
  localparam logic [10:0] ID_VENDOR = 11'h055;
  localparam logic ID_PRESENT = 1'h1;
  localparam logic [ID_W-1:0] ID_CODE = {ID_REVISION, ID_DEPTH, ID_WIDTH,
    ID_DEVICE, ID_VENDOR, ID_PRESENT};

  // ----------------------------------------------------------------
  // Data register selection
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    SEL_BYPASS = 2'h0,
    SEL_ID = 2'h1,
    SEL_BSR = 2'h2
  } sbst_sel_t;

  typedef enum logic [15:0]
  {
    ST_TLR = 16'h0001,
    ST_RTI = 16'h0002,
    ST_SELDR = 16'h0004,
    ST_CAPDR = 16'h0008,
    ST_SHDR = 16'h0010,
    ST_EX1DR = 16'h0020,
    ST_PAUSEDR = 16'h0040,
    ST_EX2DR = 16'h0080,
    ST_UPDDR = 16'h0100,
    ST_SELIR = 16'h0200,
    ST_CAPIR = 16'h0400,
    ST_SHIR = 16'h0800,
    ST_EX1IR = 16'h1000,
    ST_PAUSEIR = 16'h2000,
    ST_EX2IR = 16'h4000,
    ST_UPDIR = 16'h8000
  } sbst_state_t;

endpackage

// >>> src/sbst_fifo.sv
`timescale 1ns/1ns
module sbst_fifo #(
  parameter int WIDTH = 90,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rstSync_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  wire doWrite = inValid && inReady;
  wire doRead = outValid && outReady;

  assign inReady = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData = mem[rdPtr_r];

  always_ff @(posedge clk)
  begin
    if (doWrite)
      mem[wrPtr_r] <= inData;
  end

  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (doWrite)
        wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
      if (doRead)
        rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
      if (doWrite && !doRead)
        count_r <= count_r + 1'b1;
      else if (doRead && !doWrite)
        count_r <= count_r - 1'b1;
    end
  end

endmodule

// >>> verif/sbst_link_ctrl.sv
`timescale 1ns/1ns
module sbst_link_ctrl (
  input wire logic clk,
  output logic tck,
  output logic tms,
  output logic tmsDriven,
  output logic tdi,
  output logic tdiDriven,
  input wire logic tdo,
  input wire logic tdoOe_n
);
  // ------------------------------------------------------------
  // Test controller, one link clock per tick
  // ------------------------------------------------------------
  initial
  begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
    tmsDriven = 1'h1;
    tdiDriven = 1'h1;
  end

  task automatic setDrive(input logic on);
    @(posedge clk);
    tmsDriven <= on;
    tdiDriven <= on;
  endtask

  // Four clocks low, four high: 80 ns, below the 20 MHz ceiling
  task automatic tick(input logic m, input logic d, output logic q,
    output logic oe);
    @(posedge clk);
    tck <= 1'h0;
    // Released lines show the inverse of the last value
    tms <= tmsDriven ? m : ~tms;
    tdi <= tdiDriven ? d : ~tdi;
    repeat (4) @(posedge clk);
    tck <= 1'h1;
    // Late in the high phase the output of the last fall has settled
    repeat (3) @(posedge clk);
    q = tdo;
    oe = tdoOe_n;
  endtask
endmodule

// >>> verif/testbench.sv
`timescale 1ns/1ns
module testbench;
  // ------------------------------------------------------------
  // Instances and model state
  // ------------------------------------------------------------
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic tck, tms, tmsDriven, tdi, tdiDriven, tdo, tdoOe_n;
  logic ringValid = 1'h0;
  logic ringReady, pinOverride, memOutFloat;
  logic [sbst_pkg::BSR_W-1:0] ringData = '0;
  logic [sbst_pkg::BSR_W-1:0] cellOut;
  logic [sbst_pkg::BSR_W-1:0] cellExp;
  logic [sbst_pkg::BSR_W-1:0] ringQ[$];
  logic [31:0] seed = 32'he;
  int n_fail = 0;
  int n_checks = 0;

  always #5 clk = ~clk;

  sbst_tap u_sbst_tap (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms),
    .tmsDriven(tmsDriven), .tdi(tdi), .tdiDriven(tdiDriven), .tdo(tdo),
    .tdoOe_n(tdoOe_n), .ringValid(ringValid), .ringReady(ringReady),
    .ringData(ringData), .cellOut(cellOut), .pinOverride(pinOverride),
    .memOutFloat(memOutFloat));

  sbst_link_ctrl u_sbst_link_ctrl (.clk(clk), .tck(tck), .tms(tms),
    .tmsDriven(tmsDriven), .tdi(tdi), .tdiDriven(tdiDriven), .tdo(tdo),
    .tdoOe_n(tdoOe_n));

  function automatic logic [127:0] rnd();
    logic [127:0] r;
    for (int i = 0; i < 4; i++)
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      r = {r[95:0], seed};
    end
    return r;
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic cmpWord(input string what, input logic [127:0] e,
    input logic [127:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cmpBit(input string what, input logic e, input logic g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %b seen %b", what, e, g);
    end
  endtask

  // ------------------------------------------------------------
  // Scan tasks, all ending in run-test idle; shiftBits starts in a shift state
  // ------------------------------------------------------------
  task automatic shiftBits(input logic [127:0] din, input int n,
    output logic [127:0] dout);
    logic q, oe;
    dout = '0;
    for (int i = 0; i < n; i++)
    begin
      u_sbst_link_ctrl.tick(logic'(i == n - 1), din[i], q, oe);
      dout[i] = q;
      cmpBit("shift enable", 1'h0, oe);
    end
    u_sbst_link_ctrl.tick(1'h1, 1'h1, q, oe);
    cmpBit("exit enable", 1'h1, oe);
    u_sbst_link_ctrl.tick(1'h0, 1'h1, q, oe);
    // The update rise lands on this edge; look only once it has settled
    @(negedge clk);
  endtask

  // Only four of the five defined codes are ever loaded, never IDCODE
  task automatic irScan(input logic [2:0] op);
    logic q, oe;
    logic [127:0] cap;
    for (int i = 0; i < 4; i++)
      u_sbst_link_ctrl.tick(logic'(i < 2), 1'h1, q, oe);
    shiftBits({125'h0, op}, 3, cap);
    cmpWord("ir capture", 128'h1, cap);
  endtask

  task automatic drScan(input logic [127:0] din, input int n,
    output logic [127:0] dout);
    logic q, oe;
    for (int i = 0; i < 3; i++)
      u_sbst_link_ctrl.tick(logic'(i == 0), 1'h1, q, oe);
    shiftBits(din, n, dout);
  endtask

  // Snapshot held stable in the buffer until capture
  task automatic push(input logic [89:0] d, output logic took);
    @(posedge clk);
    ringValid <= 1'h1;
    ringData <= d;
    took = 1'h0;
    for (int i = 0; i < 3 && !took; i++)
    begin
      @(posedge clk);
      took = (ringReady === 1'h1);
    end
    ringValid <= 1'h0;
    if (took)
      ringQ.push_back(d);
  endtask

  task automatic bsrScan(input string what, input logic t89);
    logic [127:0] din, dout;
    din = rnd();
    din[89] = t89;
    drScan(din, sbst_pkg::BSR_W, dout);
    cmpWord(what, {38'h0, ringQ.pop_front()}, dout);
    cellExp = din[89:0];
    cmpWord("cells", {38'h0, cellExp}, {38'h0, cellOut});
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic took, q, oe;
    logic [127:0] din, dout;
    int k;
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    repeat (8) @(posedge clk);
    cmpBit("oe at reset", 1'h1, tdoOe_n);
    cmpBit("tristate cell", 1'h1, cellOut[89]);
    cmpBit("override", 1'h0, pinOverride);
    cmpBit("float", 1'h0, memOutFloat);
    $display("test reset done");
    u_sbst_link_ctrl.tick(1'h0, 1'h1, q, oe);
    drScan(rnd(), sbst_pkg::ID_W, dout);
    cmpWord("idcode", {96'h0, sbst_pkg::ID_CODE}, dout);
    cmpBit("presence", 1'h1, dout[0]);
    cmpWord("vendor", {117'h0, sbst_pkg::ID_VENDOR}, 128'(dout[11:1]));
    $display("test idcode done");
    irScan(sbst_pkg::OP_BYPASS);
    din = rnd();
    drScan(din, 8, dout);
    cmpWord("bypass", {120'h0, din[6:0], 1'h0}, dout);
    $display("test bypass done");
    k = 0;
    took = 1'h1;
    while (took && k < 40)
    begin
      din = rnd();
      push(din[89:0], took);
      k++;
    end
    if (k == 40)
    begin
      n_fail++;
      final_report();
    end
    cmpWord("depth", 128'(sbst_pkg::FIFO_DEPTH), 128'(ringQ.size()));
    cmpBit("full", 1'h0, ringReady);
    irScan(sbst_pkg::OP_SAMPLE);
    cmpBit("override", 1'h0, pinOverride);
    cmpBit("float", 1'h0, memOutFloat);
    while (ringQ.size() > 0)
      bsrScan("sample", seed[3]);
    cmpBit("drained", 1'h1, ringReady);
    $display("test sample done");
    irScan(sbst_pkg::OP_EXTEST);
    cmpBit("override", 1'h1, pinOverride);
    cmpBit("float", ~cellExp[89], memOutFloat);
    for (int v = 0; v < 2; v++)
    begin
      din = rnd();
      push(din[89:0], took);
      bsrScan("extest", logic'(v));
      cmpBit("float", logic'(v == 0), memOutFloat);
    end
    $display("test extest done");
    din = rnd();
    push(din[89:0], took);
    irScan(sbst_pkg::OP_SAMPLEZ);
    cmpBit("float", 1'h1, memOutFloat);
    cmpBit("override", 1'h0, pinOverride);
    bsrScan("samplez", 1'h0);
    $display("test samplez done");
    // Park in pause-data, five rises away from test-logic reset
    for (int i = 0; i < 5; i++)
      u_sbst_link_ctrl.tick(logic'(i == 0 || i == 3), 1'h1, q, oe);
    u_sbst_link_ctrl.setDrive(1'h0);
    repeat (4) u_sbst_link_ctrl.tick(1'h0, 1'h0, q, oe);
    repeat (4) @(posedge clk);
    cmpBit("four rises", 1'h1, memOutFloat);
    u_sbst_link_ctrl.tick(1'h0, 1'h0, q, oe);
    u_sbst_link_ctrl.setDrive(1'h1);
    repeat (4) @(posedge clk);
    cmpBit("float", 1'h0, memOutFloat);
    cmpBit("override", 1'h0, pinOverride);
    cmpBit("tristate cell", 1'h1, cellOut[89]);
    cmpBit("oe", 1'h1, tdoOe_n);
    $display("test link reset done");
    final_report();
  end
endmodule
